/* ram_access_monitor.sv */
// RAM access monitor: snoops the target bus and keeps per-location records.
// Assumes bus and command inputs are synchronous to ref_clk.
`timescale 1ns/1ps
// Contract
// - Track sixteen kilobytes of locations in total
// - Contiguous range or thirty-two 512-byte blocks
// - Default area starts at internal RAM base
// - Record last access kind, else not accessed
// - Flag reads of never-written locations
// - Flag locations written but not read since
// - Records come only from snooped bus accesses
// - Uninitialised read gives an event pulse
// - Accept every access once initialised, never stall target
// - History clear returns attributes to none
// - Error clear resets all error flags separately
module ram_access_monitor #(
   parameter int ADDR_W = 24,
   parameter logic [ADDR_W-1:0] RAM_BASE =
      ADDR_W'(ram_monitor_pkg::DEFAULT_RAM_BASE)
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic busValid,
   input wire logic busWrite,
   input wire logic [ADDR_W-1:0] busAddr,
   input wire logic cfgLoad,
   input wire logic cfgBlockMode,
   input wire logic [ADDR_W-1:0] cfgBase,
   input wire logic [ram_monitor_pkg::NUM_BLOCKS-1:0] blockEn,
   input wire logic [ram_monitor_pkg::NUM_BLOCKS*
      (ADDR_W-ram_monitor_pkg::BLK_OFS_W)-1:0] blockBase,
   input wire logic histClear,
   input wire logic errClear,
   input wire logic [ram_monitor_pkg::IDX_W-1:0] queryIdx,
   output logic [1:0] queryAttr,
   output logic queryErrUninit,
   output logic queryErrUnread,
   output logic uninitReadEvent,
   output logic clearBusy,
   output logic initDone
);

   localparam int IW = ram_monitor_pkg::IDX_W;
   localparam int EW = ram_monitor_pkg::ENTRY_W;
   localparam int BW = ADDR_W - ram_monitor_pkg::BLK_OFS_W;
   localparam logic [IW-1:0] LAST_IDX =
      IW'(ram_monitor_pkg::TRACK_BYTES - 1);

   // ------------------------------------------------------------------
   // Entry normalisation
   // ------------------------------------------------------------------
   // A stale stamp means a clear has passed the entry by in spirit
   function automatic logic [EW-1:0] normalise(input logic [EW-1:0] e,
         input logic gh, input logic ge);
      logic [EW-1:0] r;
      r = e;
      if (e[ram_monitor_pkg::F_GEN_H] != gh) begin
         r[ram_monitor_pkg::F_ATTR +: 2] = ram_monitor_pkg::ATTR_NONE;
         r[ram_monitor_pkg::F_EVER_W] = 1'b0;
         r[ram_monitor_pkg::F_GEN_H] = gh;
      end
      if (e[ram_monitor_pkg::F_GEN_E] != ge) begin
         r[ram_monitor_pkg::F_ERR_UNINIT] = 1'b0;
         r[ram_monitor_pkg::F_ERR_UNREAD] = 1'b0;
         r[ram_monitor_pkg::F_GEN_E] = ge;
      end
      return r;
   endfunction

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   logic blockMode_reg, blockMode_next;    // Area placed as blocks
   logic [ADDR_W-1:0] base_reg, base_next; // Contiguous area start
   logic genH_reg, genH_next;              // Current history stamp
   logic genE_reg, genE_next;              // Current error stamp
   ram_monitor_pkg::sweep_t sw_reg, sw_next;
   logic [IW-1:0] swPtr_reg, swPtr_next;   // Sweep position
   logic done_reg, done_next;              // Table fully initialised
   logic s2Valid_reg, s2Valid_next;        // Update stage busy
   ram_monitor_pkg::op_t s2Op_reg, s2Op_next;
   logic [IW-1:0] s2Idx_reg, s2Idx_next;
   logic lwValid_reg, lwValid_next;        // Last write, for forwarding
   logic [IW-1:0] lwIdx_reg, lwIdx_next;
   logic [EW-1:0] lwData_reg, lwData_next;
   logic event_reg, event_next;            // Uninitialised read pulse
   logic [EW-1:0] query_reg, query_next;   // Normalised inspection word

   logic hit;                  // Access lands in the tracked area
   logic [IW-1:0] hitIdx;      // Table index of that access
   logic snoopGo;              // Access enters the pipeline now
   logic sweepGo;              // Sweep takes the free slot
   logic [IW-1:0] rdIdx;       // Index issued to the table
   logic [EW-1:0] rdA, rdB;    // Table read data
   logic [EW-1:0] cur, upd;    // Current and updated entry
   logic wrEn;
   logic normEver;             // Ever-written bit after pending clears

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------
   // Blocks are 512-aligned so a block match is one equality on the top bits
   always_comb begin
      logic [ADDR_W-1:0] diff;
      logic found;
      logic [ram_monitor_pkg::BLK_SEL_W-1:0] blk;
      diff = busAddr - base_reg;
      found = 1'b0;
      blk = '0;
      for (int b = 0; b < ram_monitor_pkg::NUM_BLOCKS; b++) begin
         if (!found && blockEn[b] &&
               blockBase[b*BW +: BW] == busAddr[ADDR_W-1 -: BW]) begin
            found = 1'b1;
            blk = ram_monitor_pkg::BLK_SEL_W'(b);
         end
      end
      if (blockMode_reg) begin
         hit = found;
         hitIdx = {blk, busAddr[ram_monitor_pkg::BLK_OFS_W-1:0]};
      end else begin
         hit = diff < ADDR_W'(ram_monitor_pkg::TRACK_BYTES);
         hitIdx = diff[IW-1:0];
      end
   end

   // Only in-area bus cycles after the start-up sweep reach the table; the sweep takes the other slots
   assign snoopGo = busValid && hit && done_reg;
   assign sweepGo = (sw_reg != ram_monitor_pkg::SW_IDLE) && !snoopGo;
   assign rdIdx = snoopGo ? hitIdx : swPtr_reg;

   // ------------------------------------------------------------------
   // Table
   // ------------------------------------------------------------------
   track_mem #(.WIDTH(EW), .DEPTH(ram_monitor_pkg::TRACK_BYTES),
         .AW(IW)) u_mem (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .wrEn(wrEn),
      .wrAddr(s2Idx_reg),
      .wrData(upd),
      .rdAddrA(rdIdx),
      .rdDataA(rdA),
      .rdAddrB(queryIdx),
      .rdDataB(rdB)
   );

   // ------------------------------------------------------------------
   // Update stage: read-modify-write one entry per cycle
   // ------------------------------------------------------------------
   // The table returns old data when written and read in one cycle,
   // so the word written last cycle is forwarded instead
   always_comb begin
      logic [EW-1:0] n;
      cur = (lwValid_reg && lwIdx_reg == s2Idx_reg) ? lwData_reg : rdA;
      n = normalise(cur, genH_reg, genE_reg);
      normEver = n[ram_monitor_pkg::F_EVER_W];
      upd = n;
      event_next = 1'b0;
      case (s2Op_reg)
         ram_monitor_pkg::OP_WRITE: begin
            upd[ram_monitor_pkg::F_ATTR +: 2] =
               ram_monitor_pkg::ATTR_WRITTEN;
            upd[ram_monitor_pkg::F_EVER_W] = 1'b1;
            upd[ram_monitor_pkg::F_ERR_UNREAD] = 1'b1;
         end
         ram_monitor_pkg::OP_READ: begin
            upd[ram_monitor_pkg::F_ATTR +: 2] =
               ram_monitor_pkg::ATTR_READ;
            upd[ram_monitor_pkg::F_ERR_UNREAD] = 1'b0;
            if (!n[ram_monitor_pkg::F_EVER_W]) begin
               upd[ram_monitor_pkg::F_ERR_UNINIT] = 1'b1;
               event_next = s2Valid_reg;
            end
         end
         ram_monitor_pkg::OP_INIT: begin
            // Unknown contents become a clean, never-accessed entry
            upd = '0;
            upd[ram_monitor_pkg::F_GEN_H] = genH_reg;
            upd[ram_monitor_pkg::F_GEN_E] = genE_reg;
         end
         default: begin
            upd = n; // Sweep only refreshes stale fields
         end
      endcase
      wrEn = s2Valid_reg;
      lwValid_next = s2Valid_reg;
      lwIdx_next = s2Idx_reg;
      lwData_next = upd;
      s2Valid_next = snoopGo || sweepGo;
      s2Idx_next = rdIdx;
      if (snoopGo) begin
         s2Op_next = busWrite ? ram_monitor_pkg::OP_WRITE
                              : ram_monitor_pkg::OP_READ;
      end else if (sw_reg == ram_monitor_pkg::SW_INIT) begin
         s2Op_next = ram_monitor_pkg::OP_INIT;
      end else begin
         s2Op_next = ram_monitor_pkg::OP_SWEEP;
      end
      query_next = normalise(rdB, genH_reg, genE_reg);
   end

   // ------------------------------------------------------------------
   // Configuration, clears and sweep control
   // ------------------------------------------------------------------
   // A clear flips a stamp at once; the sweep only tidies up behind it,
   // so a clear costs the target bus nothing
   always_comb begin
      blockMode_next = blockMode_reg;
      base_next = base_reg;
      genH_next = genH_reg;
      genE_next = genE_reg;
      sw_next = sw_reg;
      swPtr_next = swPtr_reg;
      done_next = done_reg;
      if (cfgLoad) begin
         blockMode_next = cfgBlockMode;
         base_next = cfgBase;
      end
      case (sw_reg)
         ram_monitor_pkg::SW_IDLE: begin
            // Clears that arrive while a sweep runs are ignored
            if (histClear || errClear) begin
               genH_next = genH_reg ^ histClear;
               genE_next = genE_reg ^ errClear;
               sw_next = ram_monitor_pkg::SW_CLEAR;
               swPtr_next = '0;
            end
         end
         ram_monitor_pkg::SW_INIT, ram_monitor_pkg::SW_CLEAR: begin
            if (sweepGo) begin
               if (swPtr_reg == LAST_IDX) begin
                  sw_next = ram_monitor_pkg::SW_IDLE;
                  done_next = 1'b1;
               end else begin
                  swPtr_next = swPtr_reg + IW'(1);
               end
            end
         end
         default: begin
            sw_next = ram_monitor_pkg::SW_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         blockMode_reg <= 1'b0;
         base_reg <= RAM_BASE;
         genH_reg <= 1'b0;
         genE_reg <= 1'b0;
         sw_reg <= ram_monitor_pkg::SW_INIT;
         swPtr_reg <= '0;
         done_reg <= 1'b0;
         s2Valid_reg <= 1'b0;
         s2Op_reg <= ram_monitor_pkg::OP_INIT;
         s2Idx_reg <= '0;
         lwValid_reg <= 1'b0;
         lwIdx_reg <= '0;
         lwData_reg <= '0;
         event_reg <= 1'b0;
         query_reg <= '0;
      end else begin
         blockMode_reg <= blockMode_next;
         base_reg <= base_next;
         genH_reg <= genH_next;
         genE_reg <= genE_next;
         sw_reg <= sw_next;
         swPtr_reg <= swPtr_next;
         done_reg <= done_next;
         s2Valid_reg <= s2Valid_next;
         s2Op_reg <= s2Op_next;
         s2Idx_reg <= s2Idx_next;
         lwValid_reg <= lwValid_next;
         lwIdx_reg <= lwIdx_next;
         lwData_reg <= lwData_next;
         event_reg <= event_next;
         query_reg <= query_next;
      end
   end

   assign uninitReadEvent = event_reg;
   assign clearBusy = done_reg && (sw_reg != ram_monitor_pkg::SW_IDLE);
   assign initDone = done_reg;
   assign queryAttr = query_reg[ram_monitor_pkg::F_ATTR +: 2];
   assign queryErrUninit = query_reg[ram_monitor_pkg::F_ERR_UNINIT];
   assign queryErrUnread = query_reg[ram_monitor_pkg::F_ERR_UNREAD];

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence sSnoopWr;
      s2Valid_reg && s2Op_reg == ram_monitor_pkg::OP_WRITE;
   endsequence
   sequence sSnoopRd;
      s2Valid_reg && s2Op_reg == ram_monitor_pkg::OP_READ;
   endsequence

   AST_TRACK_SIZE: assert property (
      busValid && done_reg && !blockMode_reg &&
      busAddr - base_reg == ADDR_W'(ram_monitor_pkg::TRACK_BYTES)
      |=> !s2Valid_reg || s2Op_reg == ram_monitor_pkg::OP_SWEEP)
      else $error("access one past the area was tracked");
   AST_BLOCK_IDX: assert property (
      busValid && done_reg && blockMode_reg && hit
      |=> s2Idx_reg[ram_monitor_pkg::BLK_OFS_W-1:0] ==
          $past(busAddr[ram_monitor_pkg::BLK_OFS_W-1:0]))
      else $error("block offset not kept in table index");
   AST_WR_ATTR: assert property (
      sSnoopWr |-> wrEn &&
      upd[ram_monitor_pkg::F_ATTR +: 2] == ram_monitor_pkg::ATTR_WRITTEN &&
      upd[ram_monitor_pkg::F_ERR_UNREAD])
      else $error("write not recorded as written and unread");
   AST_RD_ATTR: assert property (
      sSnoopRd |-> wrEn && !upd[ram_monitor_pkg::F_ERR_UNREAD] &&
      upd[ram_monitor_pkg::F_ATTR +: 2] == ram_monitor_pkg::ATTR_READ)
      else $error("read not recorded as read");
   AST_UNINIT_EVT: assert property (
      sSnoopRd ##0 !normEver |=> uninitReadEvent)
      else $error("uninitialised read gave no event");
   AST_EVT_CAUSE: assert property (
      uninitReadEvent |-> $past(s2Valid_reg) && !$past(normEver) &&
      $past(s2Op_reg) == ram_monitor_pkg::OP_READ)
      else $error("event without a read");
   AST_NO_STALL: assert property (
      busValid && hit && done_reg |=> s2Valid_reg &&
      s2Op_reg == (($past(busWrite)) ? ram_monitor_pkg::OP_WRITE
                                     : ram_monitor_pkg::OP_READ))
      else $error("snooped access dropped");
   AST_OUT_RANGE: assert property (
      busValid && !hit |=> !s2Valid_reg ||
      s2Op_reg == ram_monitor_pkg::OP_SWEEP ||
      s2Op_reg == ram_monitor_pkg::OP_INIT)
      else $error("out-of-area access touched the table");
   AST_HIST_CLR: assert property (
      sw_reg == ram_monitor_pkg::SW_IDLE && histClear && !errClear
      |=> genH_reg != $past(genH_reg) && genE_reg == $past(genE_reg)
          && clearBusy)
      else $error("history clear not independent of errors");
   AST_ERR_CLR: assert property (
      s2Valid_reg && s2Op_reg == ram_monitor_pkg::OP_SWEEP &&
      cur[ram_monitor_pkg::F_GEN_E] != genE_reg
      |-> !upd[ram_monitor_pkg::F_ERR_UNINIT] &&
          !upd[ram_monitor_pkg::F_ERR_UNREAD])
      else $error("error clear left a flag set");

endmodule

/* ram_monitor_pkg.sv */
// Shared constants and types of the RAM access monitor.
// Assumes a tool with SystemVerilog package support; no timescale here.
package ram_monitor_pkg;

   // ------------------------------------------------------------------
   // Tracked area geometry
   // ------------------------------------------------------------------
   localparam int TRACK_BYTES = 16384;     // Total tracked locations
   localparam int IDX_W = 14;              // Index width of the table
   localparam int BLOCK_BYTES = 512;       // Size of one placed block
   localparam int BLK_OFS_W = 9;           // Offset width inside a block
   localparam int NUM_BLOCKS = 32;         // Placed blocks in block mode
   localparam int BLK_SEL_W = 5;           // Block number width

   // Internal RAM base after reset; value is arbitrary, set per target
   localparam logic [31:0] DEFAULT_RAM_BASE = 32'h0000_0000;

   // ------------------------------------------------------------------
   // Entry layout of one tracked location
   // ------------------------------------------------------------------
   localparam int F_ATTR = 0;          // Two bits: last access kind
   localparam int F_EVER_W = 2;        // A write has been seen
   localparam int F_ERR_UNINIT = 3;    // Read before any write
   localparam int F_ERR_UNREAD = 4;    // Written, not read since
   localparam int F_GEN_H = 5;         // History generation stamp
   localparam int F_GEN_E = 6;         // Error generation stamp
   localparam int ENTRY_W = 7;

   // Last access attribute of a location
   typedef enum logic [1:0] {ATTR_NONE, ATTR_READ, ATTR_WRITTEN} attr_t;

   // Operation carried by the update pipeline
   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_SWEEP, OP_INIT} op_t;

   // Background sweep state
   typedef enum logic [1:0] {SW_INIT, SW_IDLE, SW_CLEAR} sweep_t;

endpackage

/* track_mem.sv */
// Tracking table: one write port, two read ports with registered data.
// Assumes the caller resolves a read and a write to one word in one cycle.
`timescale 1ns/1ps
module track_mem #(
   parameter int WIDTH = 7,
   parameter int DEPTH = 16384,
   parameter int AW = 14
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic wrEn,              // Write strobe
   input wire logic [AW-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   input wire logic [AW-1:0] rdAddrA,  // Update pipeline port
   output logic [WIDTH-1:0] rdDataA,
   input wire logic [AW-1:0] rdAddrB,  // Inspection port
   output logic [WIDTH-1:0] rdDataB
);

   logic [WIDTH-1:0] mem [DEPTH];      // Storage, no reset: swept at start

   // ------------------------------------------------------------------
   // Storage write; array left unreset so it maps onto block RAM
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // ------------------------------------------------------------------
   // Registered reads, old data on a same-cycle write
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdDataA <= '0;
         rdDataB <= '0;
      end else begin
         rdDataA <= mem[rdAddrA];
         rdDataB <= mem[rdAddrB];
      end
   end

endmodule

/* target_bus_model.sv */
// Model of the snooped target bus: one slot per cycle from a queue.
// Assumes the bench pushes slots and polls the queue depth.
`timescale 1ns/1ps
module target_bus_model #(
   parameter int ADDR_W = 24
) (
   input wire logic ref_clk,
   output logic busValid,
   output logic busWrite,
   output logic [ADDR_W-1:0] busAddr
);
   // ---------------------------------------------
   // Slot queue
   // ---------------------------------------------
   typedef struct {bit v; bit w; logic [ADDR_W-1:0] a;} slot_t;
   slot_t q[$]; // Slots not yet on the bus

   // Queue one slot; v=0 is an idle slot, a slow target cycle
   task automatic push(input bit v, input bit w,
      input logic [ADDR_W-1:0] a);
      q.push_back('{v, w, a});
   endtask

   // Slots still waiting
   function automatic int depth();
      return q.size();
   endfunction

   // ---------------------------------------------
   // Bus driver
   // ---------------------------------------------
   initial begin
      busValid = 1'b0;
      busWrite = 1'b0;
      busAddr = '0;
   end

   // Never waits on the monitor: the target cannot be stalled
   always @(posedge ref_clk) begin
      slot_t s;
      #1;
      s = '{1'b0, 1'b0, '0};
      if (q.size() != 0) begin
         s = q.pop_front();
      end
      busValid = s.v;
      if (s.v) begin
         busWrite = s.w;
         busAddr = s.a;
      end else begin
         // Idle lines wiggle so a stale value cannot look like a cycle
         busWrite = ~busWrite;
         busAddr = ~busAddr;
      end
   end
endmodule

/* tb_top.sv */
// Self-checking bench of the RAM access monitor with a reference model.
// Assumes the bus model file is compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
miscompares++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
   localparam int AW = 24;
   localparam int N = ram_monitor_pkg::TRACK_BYTES;
   // ---------------------------------------------
   // Design signals; the inputs the bench drives get a value at time zero
   // ---------------------------------------------
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic busValid;
   logic busWrite;
   logic [AW-1:0] busAddr;
   logic cfgLoad = 1'b0;
   logic cfgBlockMode = 1'b0;
   logic [AW-1:0] cfgBase = '0;
   logic [31:0] blockEn = '0;
   logic [32*15-1:0] blockBase = '0;
   logic histClear = 1'b0;
   logic errClear = 1'b0;
   logic [13:0] queryIdx = '0;
   logic [1:0] queryAttr;
   logic queryErrUninit;
   logic queryErrUnread;
   logic uninitReadEvent;
   logic clearBusy;
   logic initDone;
   // ---------------------------------------------
   // Reference model state
   // ---------------------------------------------
   int mAttr[N]; // 0 none, 1 read, 2 written
   bit mEver[N]; // A write seen since history clear
   bit mUni[N];
   bit mUnr[N];
   bit seen[int]; // Indices to inspect
   bit mLive = 1'b0; // Table ready, accesses count
   bit mBlk = 1'b0;
   int mBase = 0;
   int mBB[32];
   int evExp = 0;
   int evSeen = 0;
   int miscompares = 0;
   int n_checks = 0;
   logic [31:0] r;

   always #2.5 ref_clk = ~ref_clk;

   target_bus_model #(.ADDR_W(AW)) target_bus_model_inst (
      .ref_clk(ref_clk), .busValid(busValid), .busWrite(busWrite),
      .busAddr(busAddr));

   ram_access_monitor #(.ADDR_W(AW)) ram_access_monitor_inst (
      .ref_clk(ref_clk), .reset_n(reset_n), .busValid(busValid),
      .busWrite(busWrite), .busAddr(busAddr), .cfgLoad(cfgLoad),
      .cfgBlockMode(cfgBlockMode), .cfgBase(cfgBase), .blockEn(blockEn),
      .blockBase(blockBase), .histClear(histClear), .errClear(errClear),
      .queryIdx(queryIdx), .queryAttr(queryAttr),
      .queryErrUninit(queryErrUninit), .queryErrUnread(queryErrUnread),
      .uninitReadEvent(uninitReadEvent), .clearBusy(clearBusy),
      .initDone(initDone));

   // Count event pulses; one per uninitialised read
   always @(posedge ref_clk) begin
      if (uninitReadEvent === 1'b1) evSeen++;
   end

   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic timeout(string nm);
      miscompares++;
      $display("Error %s expected done seen timeout", nm);
      report_and_stop();
   endtask

   // Area lookup; -1 when the address is outside every area
   function automatic int map_addr(int a);
      int d;
      d = (a - mBase) & 24'hFFFFFF;
      if (!mBlk) return (d < N) ? d : -1;
      for (int b = 0; b < 32; b++) begin
         if (blockEn[b] && (a >> 9) == mBB[b]) return b * 512 + (a & 'h1FF);
      end
      return -1;
   endfunction

   // One snooped access on the bus and in the model
   task automatic acc(bit w, int a);
      int i;
      i = map_addr(a);
      target_bus_model_inst.push(1'b1, w, AW'(a));
      if (i < 0) return;
      seen[i] = 1'b1;
      if (!mLive) return;
      if (w) begin
         mAttr[i] = 2;
         mEver[i] = 1'b1;
         mUnr[i] = 1'b1;
      end else begin
         if (!mEver[i]) begin
            mUni[i] = 1'b1;
            evExp++;
         end
         mAttr[i] = 1;
         mUnr[i] = 1'b0;
      end
   endtask

   // Let the bus run dry and the pipeline settle
   task automatic drain();
      int k;
      for (k = 0; k < 5000 && target_bus_model_inst.depth() != 0; k++)
         @(posedge ref_clk);
      if (k == 5000) timeout("bus drain");
      repeat (4) @(posedge ref_clk);
      #1;
      `CHK("event count", evExp, evSeen)
   endtask

   // Index held three edges, so the outputs are settled on it
   task automatic inspect_all();
      foreach (seen[i]) begin
         queryIdx = 14'(i);
         repeat (3) @(posedge ref_clk);
         #1;
         `CHK("attr", 2'(mAttr[i]), queryAttr)
         `CHK("uninit flag", mUni[i], queryErrUninit)
         `CHK("unread flag", mUnr[i], queryErrUnread)
      end
   endtask

   task automatic clear_cmd(bit h, bit e);
      histClear = h;
      errClear = e;
      @(posedge ref_clk);
      #1;
      histClear = 1'b0;
      errClear = 1'b0;
      for (int i = 0; i < N; i++) begin
         if (h) mAttr[i] = 0;
         if (h) mEver[i] = 1'b0;
         if (e) mUni[i] = 1'b0;
         if (e) mUnr[i] = 1'b0;
      end
      @(posedge ref_clk);
      #1;
      `CHK("busy after clear", 1'b1, clearBusy)
   endtask

   task automatic wait_idle();
      int k;
      for (k = 0; k < 40000 && clearBusy !== 1'b0; k++) @(posedge ref_clk);
      if (k == 40000) timeout("clear sweep");
      #1;
   endtask

   task automatic load_cfg(bit blk, int base);
      cfgBlockMode = blk;
      cfgBase = AW'(base);
      cfgLoad = 1'b1;
      @(posedge ref_clk);
      #1;
      cfgLoad = 1'b0;
      mBlk = blk;
      mBase = base;
   endtask

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      int k;
      void'($urandom(32'h7192));
      repeat (4) @(posedge ref_clk);
      #1;
      reset_n = 1'b1;
      // Accesses during the start-up sweep leave no trace
      acc(1'b0, 24'h40);
      acc(1'b1, 24'h41);
      drain();
      `CHK("ready during sweep", 1'b0, initDone)
      for (k = 0; k < 20000 && initDone !== 1'b1; k++) @(posedge ref_clk);
      if (k == 20000) timeout("start-up sweep");
      #1;
      mLive = 1'b1;
      seen[0] = 1'b1;
      seen[1] = 1'b1;
      // Default area from the RAM base, back to back, top end inside and out
      acc(1'b0, 24'h10);
      acc(1'b0, 24'h10);
      acc(1'b1, 24'h20);
      acc(1'b1, 24'h30);
      acc(1'b0, 24'h30);
      acc(1'b1, 24'h3FFF);
      acc(1'b1, 24'h4000);
      acc(1'b0, 24'h4001);
      // Random mix with idle slots and out-of-area hits
      for (int n = 0; n < 300; n++) begin
         r = $urandom;
         if (r[3:0] == 4'h0) target_bus_model_inst.push(1'b0, 1'b0, '0);
         else acc(r[4], (r[5] ? 'h4000 : 0) + r[11:6]);
      end
      drain();
      inspect_all();
      // Moved contiguous area
      load_cfg(1'b0, 24'h012000);
      acc(1'b0, 24'h012005);
      acc(1'b1, 24'h011FFF);
      acc(1'b1, 24'h015FFF);
      drain();
      // Block mode; blocks 3 and 31 overlap, lowest wins
      for (int b = 0; b < 32; b++) begin
         mBB[b] = $urandom & 'h7FFF;
      end
      mBB[3] = 'h1234;
      mBB[31] = 'h1234;
      mBB[7] = 'h0ABC;
      for (int b = 0; b < 32; b++) blockBase[b*15 +: 15] = 15'(mBB[b]);
      blockEn = 32'h80000009;
      load_cfg(1'b1, 0);
      acc(1'b0, {15'h1234, 9'h1FF});
      acc(1'b1, {15'h1234, 9'h000});
      acc(1'b1, {15'h0ABC, 9'h005});
      acc(1'b1, {15'(mBB[0]), 9'h100});
      drain();
      inspect_all();
      // History clear, traffic while sweeping, refused second clear
      clear_cmd(1'b1, 1'b0);
      acc(1'b0, {15'h1234, 9'h000});
      errClear = 1'b1;
      @(posedge ref_clk);
      #1;
      errClear = 1'b0;
      wait_idle();
      drain();
      inspect_all();
      // Error clear keeps the access kinds
      clear_cmd(1'b0, 1'b1);
      wait_idle();
      inspect_all();
      // Both clears at once, then a write while the sweep runs
      clear_cmd(1'b1, 1'b1);
      acc(1'b1, {15'h1234, 9'h1FF});
      wait_idle();
      drain();
      inspect_all();
      report_and_stop();
   end
endmodule
